// [bacr_pkg.sv]
package bacr_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [9:0] HOST_INTERFACE_OPTIONS_OFS        = 10'h106;
   localparam logic [9:0] ALARM_PIN_AND_TIMEOUT_CONFIG_OFS  = 10'h143;
   localparam logic [9:0] SPARE_CONFIG_OFS                  = 10'h144;
   localparam logic [9:0] GPIO_PULL_CONFIG_OFS              = 10'h145;
   localparam logic [9:0] ALARM_MASKING_AND_RAMP_CONFIG_OFS = 10'h146;
   localparam logic [9:0] OSCILLATOR_TRIM_AND_ROLE_OFS      = 10'h147;
   localparam logic [9:0] CLOCK_FORCE_CONTROL_OFS           = 10'h14f;
   localparam logic [9:0] PART_IDENTIFIER_OFS               = 10'h201;
   localparam logic [9:0] SILICON_REVISION_VARIANT_OFS      = 10'h202;
   localparam logic [9:0] CUSTOMER_IDENTIFIER_OFS           = 10'h203;
   localparam logic [9:0] FUSE_SETTINGS_REVISION_OFS        = 10'h204;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int IF_TYPE_BIT         = 7;
   localparam int HIGH_SPEED_BIT      = 6;
   localparam int FAST_PLUS_BIT       = 5;
   localparam int STUCK_RESET_BIT     = 4;
   localparam int ALARM_FUNCTION_BIT  = 2;
   localparam int ALARM_DRIVE_BIT     = 1;
   localparam int ALARM_POLARITY_BIT  = 0;
   localparam int ALARM_HOLD_BIT      = 7;
   localparam int ALARM_RELEASE_BIT   = 6;
   localparam int RAMP_MASK_LSB       = 4;
   localparam int READY_ENABLE_BIT    = 3;
   localparam int KEEP_RAMP_PORT_BIT  = 2;
   localparam int RAMP_INCREMENT_BIT  = 1;
   localparam int OSC_TRIM_LSB        = 4;
   localparam int STANDALONE_BIT      = 0;
   localparam int CLOCK_FORCE_BIT     = 0;

   // ----------------------------------------------------------------
   // writable bits and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] HOST_INTERFACE_WMASK  = 8'h70;
   localparam logic [7:0] ALARM_PIN_WMASK       = 8'h1f;
   localparam logic [7:0] SPARE_WMASK           = 8'hff;
   localparam logic [7:0] GPIO_PULL_WMASK       = 8'h7f;
   localparam logic [7:0] ALARM_MASKING_WMASK   = 8'hfe;
   localparam logic [7:0] OSC_TRIM_ROLE_WMASK   = 8'h31;
   localparam logic [7:0] CLOCK_FORCE_WMASK     = 8'h01;
   localparam logic [7:0] CONFIG_RESET          = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 50;
   localparam int STUCK_TIME_MS     = 35;
   localparam int HOLD_TIME_US      = 100;
   localparam int RELEASE_TIME_US   = 250;
   localparam int EXTRA_SHORT_US    = 2;
   localparam int EXTRA_MID_US      = 10;
   localparam int EXTRA_LONG_US     = 50;
   localparam int STUCK_CYC   = (STUCK_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC    = (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_CYC = (RELEASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXTRA_SHORT_CYC = (EXTRA_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXTRA_MID_CYC   = (EXTRA_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXTRA_LONG_CYC  = (EXTRA_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [9:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } bacr_req_t;

   typedef struct packed {
      logic buck_en;
      logic ramp_active;
      logic ramp_down_done;
      logic power_good;
      logic over_current;
      logic irq;
   } bacr_rail_t;

   typedef struct packed {
      logic       permanent_high_speed_enable;
      logic       fast_plus_timing_enable;
      logic [6:0] pull_enable;
      logic       ramp_increment_select;
      logic [1:0] oscillator_trim;
      logic       standalone;
      logic       clock_force;
      logic       pin_three_mode_lock;
   } bacr_cfg_t;

endpackage

// [bacr_timer.sv]
`timescale 1ns/100ps
module bacr_timer #(
   parameter int W = 11
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // control
   input  wire logic         load_in,
   input  wire logic [W-1:0] count_in,
   // status
   output logic              busy_out
);

   logic [W-1:0] cnt;

   initial begin
      if (W < 1) $error("timer width must be at least one");
   end

   assign busy_out = (cnt != '0);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) cnt <= '0;
      else if (load_in) cnt <= count_in;
      else if (busy_out) cnt <= cnt - W'(1);
   end

endmodule // bacr_timer

// [bacr_regs.sv]
// Operation
// R01: read-only bit seven reports interface kind
// R02: bit six forces permanent high-speed two-wire
// R03: bit five selects fast-mode-plus timing
// R04: stuck low clock resets two-wire logic
// R05: bit two selects alarm pin function
// R06: bit one selects push-pull or open-drain
// R07: bit zero selects alarm active level
// R08: pull bits six to zero per GPIO
// R09: hold bit masks over-current after valid
// R10: release pin after delay or ramp-down
// R11: mask field masks over-current during ramps
// R12: ready bit drives pin three, locks mode
// R13: clear ramp port enable unless kept
// R14: step bit selects 10 or 20 mV
// R15: trim field raises oscillator frequency
// R16: role bit selects companion or stand-alone
// R17: force bit keeps oscillator and fuse clock
// R18: host sets page before upper registers
// R19: reserved bits read zero, writes ignored
`timescale 1ns/100ps
module bacr_regs
   import bacr_pkg::*;
#(
   parameter int         STUCK_CYCLES   = STUCK_CYC,
   parameter int         RELEASE_CYCLES = RELEASE_CYC,
   parameter logic [7:0] PART_CODE      = 8'h5a,  // arbitrary value
   parameter logic [3:0] MASK_REVISION  = 4'h1,   // arbitrary value
   parameter logic [3:0] VARIANT_CODE   = 4'h2,   // arbitrary value
   parameter logic [7:0] CUSTOMER_CODE  = 8'h00,  // arbitrary value
   parameter logic [7:0] FUSE_VERSION   = 8'h01   // arbitrary value
) (
   // clock and reset
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_N_IN,
   // register access from the serial engine
   input  wire bacr_req_t   REG_REQ_IN,
   output logic [7:0]       REG_RDATA_OUT,
   // pins
   input  wire logic        IF_TYPE_STRAP_IN,
   input  wire logic        SERIAL_CLK_IN,
   // rail status
   input  wire bacr_rail_t  RAIL_STATUS_IN,
   // alarm pin
   output logic             ALARM_OUTPUT_PIN_OUT,
   output logic             ALARM_OUTPUT_PIN_OE_OUT,
   // pin three ready indication
   output logic             PIN_THREE_READY_OUT,
   // control outputs
   output logic             TWO_WIRE_RESET_OUT,
   output logic             RAMP_PORT_CLEAR_OUT,
   output bacr_cfg_t        CFG_OUT
);

   localparam int SW = $clog2(STUCK_CYCLES + 1);
   localparam int RW = $clog2(RELEASE_CYCLES + 1);
   localparam int HW = $clog2(HOLD_CYC + 1);

   initial begin
      if (STUCK_CYCLES < 2) $error("STUCK_CYCLES too small");
      if (RELEASE_CYCLES < 1) $error("RELEASE_CYCLES too small");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] host_interface_options;
   logic [7:0] alarm_pin_and_timeout_config;
   logic [7:0] spare_config;
   logic [7:0] gpio_pull_config;
   logic [7:0] alarm_masking_and_ramp_config;
   logic [7:0] oscillator_trim_and_role;
   logic [7:0] clock_force_control;
   logic       if_type;
   logic       strap_taken;
   logic [1:0] strap_sync;
   logic [1:0] sclk_sync;

   wire wr = REG_REQ_IN.wr;
   wire [7:0] wd = REG_REQ_IN.wdata;
   wire hit_if    = (REG_REQ_IN.addr == HOST_INTERFACE_OPTIONS_OFS);
   wire hit_alarm = (REG_REQ_IN.addr == ALARM_PIN_AND_TIMEOUT_CONFIG_OFS);
   wire hit_spare = (REG_REQ_IN.addr == SPARE_CONFIG_OFS);
   wire hit_pull  = (REG_REQ_IN.addr == GPIO_PULL_CONFIG_OFS);
   wire hit_mask  = (REG_REQ_IN.addr == ALARM_MASKING_AND_RAMP_CONFIG_OFS);
   wire hit_osc   = (REG_REQ_IN.addr == OSCILLATOR_TRIM_AND_ROLE_OFS);
   wire hit_clk   = (REG_REQ_IN.addr == CLOCK_FORCE_CONTROL_OFS);
   wire hit_part  = (REG_REQ_IN.addr == PART_IDENTIFIER_OFS);
   wire hit_rev   = (REG_REQ_IN.addr == SILICON_REVISION_VARIANT_OFS);
   wire hit_cust  = (REG_REQ_IN.addr == CUSTOMER_IDENTIFIER_OFS);
   wire hit_fuse  = (REG_REQ_IN.addr == FUSE_SETTINGS_REVISION_OFS);

   wire [7:0] rd_value =
      hit_if    ? ((host_interface_options & HOST_INTERFACE_WMASK)
                   | (8'(if_type) << IF_TYPE_BIT)) :                  // R01
      hit_alarm ? (alarm_pin_and_timeout_config & ALARM_PIN_WMASK) :  // R19
      hit_spare ? spare_config :
      hit_pull  ? (gpio_pull_config & GPIO_PULL_WMASK) :
      hit_mask  ? (alarm_masking_and_ramp_config & ALARM_MASKING_WMASK) :
      hit_osc   ? (oscillator_trim_and_role & OSC_TRIM_ROLE_WMASK) :
      hit_clk   ? (clock_force_control & CLOCK_FORCE_WMASK) :
      hit_part  ? PART_CODE :
      hit_rev   ? {MASK_REVISION, VARIANT_CODE} :
      hit_cust  ? CUSTOMER_CODE :
      hit_fuse  ? FUSE_VERSION : 8'h00;

   // reserved bits never stored
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         host_interface_options        <= CONFIG_RESET;
         alarm_pin_and_timeout_config  <= CONFIG_RESET;
         spare_config                  <= CONFIG_RESET;
         gpio_pull_config              <= CONFIG_RESET;
         alarm_masking_and_ramp_config <= CONFIG_RESET;
         oscillator_trim_and_role      <= CONFIG_RESET;
         clock_force_control           <= CONFIG_RESET;
      end else if (wr) begin
         if (hit_if) host_interface_options <= wd & HOST_INTERFACE_WMASK;         // R19
         if (hit_alarm) alarm_pin_and_timeout_config <= wd & ALARM_PIN_WMASK;
         if (hit_spare) spare_config <= wd & SPARE_WMASK;
         if (hit_pull) gpio_pull_config <= wd & GPIO_PULL_WMASK;                 // R08
         if (hit_mask) alarm_masking_and_ramp_config <= wd & ALARM_MASKING_WMASK;
         if (hit_osc) oscillator_trim_and_role <= wd & OSC_TRIM_ROLE_WMASK;
         if (hit_clk) clock_force_control <= wd & CLOCK_FORCE_WMASK;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) REG_RDATA_OUT <= 8'h00;
      else if (REG_REQ_IN.rd) REG_RDATA_OUT <= rd_value;
   end

   // ----------------------------------------------------------------
   // interface kind strap and pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         strap_sync <= 2'h0;
         sclk_sync  <= 2'h3;
      end else begin
         strap_sync <= {strap_sync[0], IF_TYPE_STRAP_IN};
         sclk_sync  <= {sclk_sync[0], SERIAL_CLK_IN};
      end
   end

   // strap caught once, after the synchroniser has filled
   logic [1:0] strap_wait;
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         strap_wait  <= 2'h0;
         strap_taken <= 1'b0;
         if_type     <= 1'b0;
      end else if (!strap_taken) begin
         strap_wait <= strap_wait + 2'h1;
         if (strap_wait == 2'h2) begin
            if_type     <= strap_sync[1];   // R01
            strap_taken <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // stuck serial clock watchdog
   // ----------------------------------------------------------------
   logic [SW-1:0] stuck_cnt;
   wire stuck_en  = alarm_pin_and_timeout_config[STUCK_RESET_BIT];
   wire stuck_hit = (stuck_cnt == SW'(STUCK_CYCLES - 1));

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         stuck_cnt          <= '0;
         TWO_WIRE_RESET_OUT <= 1'b0;
      end else begin
         TWO_WIRE_RESET_OUT <= stuck_en && !sclk_sync[1] && stuck_hit;   // R04
         if (!stuck_en || sclk_sync[1]) stuck_cnt <= '0;
         else if (!(stuck_cnt == SW'(STUCK_CYCLES))) stuck_cnt <= stuck_cnt + SW'(1);
      end
   end

   // ----------------------------------------------------------------
   // rail event detection and timers
   // ----------------------------------------------------------------
   logic pg_d;
   logic ramp_d;
   logic buck_d;
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         pg_d   <= 1'b0;
         ramp_d <= 1'b0;
         buck_d <= 1'b0;
      end else begin
         pg_d   <= RAIL_STATUS_IN.power_good;
         ramp_d <= RAIL_STATUS_IN.ramp_active;
         buck_d <= RAIL_STATUS_IN.buck_en;
      end
   end

   wire       hold_en   = alarm_masking_and_ramp_config[ALARM_HOLD_BIT];
   wire       rel_sel   = alarm_masking_and_ramp_config[ALARM_RELEASE_BIT];
   wire [1:0] mask_sel  = alarm_masking_and_ramp_config[RAMP_MASK_LSB +: 2];
   wire       pg_rise   = RAIL_STATUS_IN.power_good && !pg_d;
   wire       ramp_fall = !RAIL_STATUS_IN.ramp_active && ramp_d;
   wire       buck_fall = !RAIL_STATUS_IN.buck_en && buck_d;

   wire [HW-1:0] extra_cnt =
      (mask_sel == 2'h1) ? HW'(EXTRA_SHORT_CYC) :
      (mask_sel == 2'h2) ? HW'(EXTRA_MID_CYC) : HW'(EXTRA_LONG_CYC);     // R11

   logic hold_busy;
   logic extra_busy;
   logic rel_busy;
   bacr_timer #(.W(HW)) u_hold (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (RST_N_IN),
      .load_in  (pg_rise && hold_en),            // R09
      .count_in (HW'(HOLD_CYC)),
      .busy_out (hold_busy)
   );

   bacr_timer #(.W(HW)) u_extra (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (RST_N_IN),
      .load_in  (ramp_fall && (mask_sel != 2'h0)),   // R11
      .count_in (extra_cnt),
      .busy_out (extra_busy)
   );

   bacr_timer #(.W(RW)) u_release (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (RST_N_IN),
      .load_in  (buck_fall),                     // R10
      .count_in (RW'(RELEASE_CYCLES)),
      .busy_out (rel_busy)
   );

   // ----------------------------------------------------------------
   // alarm pin
   // ----------------------------------------------------------------
   wire ramp_mask = (mask_sel != 2'h0)
                    && (RAIL_STATUS_IN.ramp_active || ramp_d || extra_busy);        // R11
   wire hold_mask = hold_busy || (pg_rise && hold_en);                                 // R09
   wire oc_shown  = RAIL_STATUS_IN.over_current && !hold_mask && !ramp_mask;           // R09
   wire func_sel  = alarm_pin_and_timeout_config[ALARM_FUNCTION_BIT];
   wire drive_od  = alarm_pin_and_timeout_config[ALARM_DRIVE_BIT];
   wire pol_high  = alarm_pin_and_timeout_config[ALARM_POLARITY_BIT];
   wire alarm_act = func_sel ? (oc_shown || !RAIL_STATUS_IN.power_good)
                             : RAIL_STATUS_IN.irq;                                     // R05
   wire released  = !RAIL_STATUS_IN.buck_en && !buck_fall
                    && (rel_sel ? RAIL_STATUS_IN.ramp_down_done : !rel_busy);          // R10
   wire pin_level = pol_high ? alarm_act : !alarm_act;                                 // R07
   wire next_oe   = !released && (!drive_od || !pin_level);                            // R06
   wire next_pin  = drive_od ? 1'b0 : pin_level;

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         ALARM_OUTPUT_PIN_OUT    <= 1'b0;
         ALARM_OUTPUT_PIN_OE_OUT <= 1'b0;
      end else begin
         ALARM_OUTPUT_PIN_OUT    <= next_pin;
         ALARM_OUTPUT_PIN_OE_OUT <= next_oe;
      end
   end

   // ----------------------------------------------------------------
   // ramp interface side effects and configuration outputs
   // ----------------------------------------------------------------
   wire ready_en = alarm_masking_and_ramp_config[READY_ENABLE_BIT];
   wire keep_rp  = alarm_masking_and_ramp_config[KEEP_RAMP_PORT_BIT];

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         PIN_THREE_READY_OUT <= 1'b0;
         RAMP_PORT_CLEAR_OUT <= 1'b0;
      end else begin
         PIN_THREE_READY_OUT <= ready_en && RAIL_STATUS_IN.ramp_active;   // R12
         RAMP_PORT_CLEAR_OUT <= buck_fall && !keep_rp;                     // R13
      end
   end

   always_comb begin
      CFG_OUT.permanent_high_speed_enable = host_interface_options[HIGH_SPEED_BIT];  // R02
      CFG_OUT.fast_plus_timing_enable     = host_interface_options[FAST_PLUS_BIT];   // R03
      CFG_OUT.pull_enable                 = gpio_pull_config[6:0];                   // R08
      CFG_OUT.ramp_increment_select       = alarm_masking_and_ramp_config[RAMP_INCREMENT_BIT]; // R14
      CFG_OUT.oscillator_trim             = oscillator_trim_and_role[OSC_TRIM_LSB +: 2];     // R15
      CFG_OUT.standalone                  = oscillator_trim_and_role[STANDALONE_BIT];        // R16
      CFG_OUT.clock_force                 = clock_force_control[CLOCK_FORCE_BIT];            // R17
      CFG_OUT.pin_three_mode_lock         = ready_en;                                        // R12
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   if_type_ro_a: assert property (strap_taken && wr && hit_if |=> $stable(if_type)) // R01
      else $error("interface kind bit changed by a write");
   high_speed_a: assert property (wr && hit_if |=>
      CFG_OUT.permanent_high_speed_enable == $past(wd[HIGH_SPEED_BIT])) // R02
      else $error("high-speed enable not taken from write");
   fast_plus_a: assert property (wr && hit_if |=>
      CFG_OUT.fast_plus_timing_enable == $past(wd[FAST_PLUS_BIT])) // R03
      else $error("fast-plus enable not taken from write");
   stuck_reset_a: assert property (TWO_WIRE_RESET_OUT |->
      $past(stuck_en) && stuck_cnt == SW'(STUCK_CYCLES)) // R04
      else $error("two-wire reset without a full stuck time");
   stuck_off_a: assert property (!stuck_en |=> !TWO_WIRE_RESET_OUT) // R04
      else $error("two-wire reset while watchdog disabled");
   irq_func_a: assert property (!func_sel && !released && !drive_od && pol_high |=>
      ALARM_OUTPUT_PIN_OUT == $past(RAIL_STATUS_IN.irq)) // R05
      else $error("alarm pin does not follow interrupt");
   drive_style_a: assert property (ALARM_OUTPUT_PIN_OE_OUT && $past(drive_od)
      |-> !ALARM_OUTPUT_PIN_OUT) // R06
      else $error("open-drain alarm pin drove high");
   polarity_low_a: assert property (!pol_high && !drive_od && !released && alarm_act
      |=> ALARM_OUTPUT_PIN_OE_OUT && !ALARM_OUTPUT_PIN_OUT) // R07
      else $error("active-low alarm not driven low");
   hold_mask_a: assert property (pg_rise && hold_en |-> !oc_shown ##1 hold_busy [*8]) // R09
      else $error("over-current hold window missing");
   release_wait_a: assert property (buck_fall && !rel_sel |=> !released [*8]) // R10
      else $error("alarm pin released before the release delay");
   ramp_mask_a: assert property (ramp_fall && mask_sel == 2'h3 |-> ramp_mask [*8]) // R11
      else $error("ramp mask did not extend after ramp");
   ready_pin_a: assert property (PIN_THREE_READY_OUT ==
      $past(ready_en && RAIL_STATUS_IN.ramp_active)) // R12
      else $error("pin three ready does not track ramp");
   ramp_clear_a: assert property (buck_fall && !keep_rp |=> RAMP_PORT_CLEAR_OUT) // R13
      else $error("ramp port enable not cleared");
   reserved_zero_a: assert property (REG_REQ_IN.rd && hit_alarm |=>
      REG_RDATA_OUT[7:5] == 3'h0) // R19
      else $error("reserved alarm bits read nonzero");

   cover_stuck: cover property (TWO_WIRE_RESET_OUT);
   cover_hold: cover property (pg_rise && hold_en ##1 RAIL_STATUS_IN.over_current);
   cover_release: cover property (buck_fall ##[1:300] released);
   cover_ramp: cover property (ramp_fall && mask_sel == 2'h1 ##[1:50] !ramp_mask);

endmodule // bacr_regs

// [bacr_host.sv]
`timescale 1ns/100ps
module bacr_host
   import bacr_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // register port
   input  wire logic [7:0] rdata_in,
   output bacr_req_t       req_out
);
   // ------------------------------
   // one strobed access, then read back
   // ------------------------------
   initial req_out = '0;
   task automatic access(input logic [9:0] a, input logic w, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk_in);
      req_out <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk_in);
      req_out <= '0;
      @(posedge clk_in);
      #1;
      q = rdata_in;
   endtask
endmodule // bacr_host

// [buck_app_config_regs_test.sv]
`timescale 1ns/100ps
module buck_app_config_regs_test;
   import bacr_pkg::*;
   logic       sys_clk;
   logic       rst_n = 1'b0;
   logic       sclk = 1'b1;
   bacr_rail_t rail = '0;
   bacr_req_t  req;
   bacr_cfg_t  cfg;
   logic [7:0] rdata;
   logic [7:0] q;
   logic       pin;
   logic       oe;
   logic       ready;
   logic       twr;
   logic       clr;
   int         err_total = 0;
   int         check_count = 0;
   int         twr_cnt = 0;
   int         clr_cnt = 0;
   int         n;
   bacr_host u_host (.clk_in(sys_clk), .rdata_in(rdata), .req_out(req));
   bacr_regs #(.STUCK_CYCLES(20), .RELEASE_CYCLES(16)) u_dut (
      .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
      .IF_TYPE_STRAP_IN(1'b1), .SERIAL_CLK_IN(sclk), .RAIL_STATUS_IN(rail),
      .ALARM_OUTPUT_PIN_OUT(pin), .ALARM_OUTPUT_PIN_OE_OUT(oe), .PIN_THREE_READY_OUT(ready),
      .TWO_WIRE_RESET_OUT(twr), .RAMP_PORT_CLEAR_OUT(clr), .CFG_OUT(cfg));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      twr_cnt <= twr_cnt + int'(twr);
      clr_cnt <= clr_cnt + int'(clr);
   end
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      u_host.access(a, 1'b1, d, q);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [7:0] e);
      u_host.access(a, 1'b0, 8'h00, q);
      chk(16'(q), 16'(e));
   endtask
   task automatic drv(input logic [5:0] r);
      @(posedge sys_clk);
      rail <= bacr_rail_t'(r);
   endtask
   task automatic results();
      if (err_total == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs();
      logic [9:0] a [8] = '{10'h106, 10'h143, 10'h144, 10'h145, 10'h146, 10'h147,
                            10'h14f, 10'h201};
      logic [7:0] r [8] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a};
      logic [7:0] e [8] = '{8'hf0, 8'h1f, 8'hff, 8'h7f, 8'hfe, 8'h31, 8'h01, 8'h5a};
      for (int i = 0; i < 8; i++) begin
         rdc(a[i], r[i]);
         wr(a[i], 8'hff);
         rdc(a[i], e[i]);
      end
      chk(16'(cfg), 16'h7fff);
      for (int i = 0; i < 8; i++) wr(a[i], 8'h00);
      chk(16'(cfg), 16'h0000);
      wr(10'h147, 8'h21);
      chk(16'(cfg), 16'h0014);
      rdc(10'h106, 8'h80);
      rdc(10'h202, 8'h12);
      rdc(10'h204, 8'h01);
      rdc(10'h150, 8'h00);
   endtask
   task automatic t_alarm();
      logic [12:0] t [10] = '{{8'h01, 5'b10111}, {8'h00, 5'b10101}, {8'h00, 5'b00111},
                              {8'h02, 5'b10101}, {8'h02, 5'b00100}, {8'h05, 5'b01111},
                              {8'h05, 5'b00101}, {8'h07, 5'b01100}, {8'h07, 5'b00101},
                              {8'h05, 5'b00011}};
      for (int i = 0; i < 10; i++) begin
         wr(10'h143, t[i][12:5]);
         drv({3'b100, t[i][2], t[i][3], t[i][4]});
         cyc(3);
         chk(16'({pin, oe}), 16'(t[i][1:0]));
      end
   endtask
   task automatic t_masks();
      int w [4] = '{0, EXTRA_SHORT_CYC, EXTRA_MID_CYC, EXTRA_LONG_CYC};
      drv(6'b110110);
      cyc(3);
      chk(16'({pin, ready}), 16'h2);
      wr(10'h146, 8'h18);
      cyc(3);
      chk(16'({pin, ready}), 16'h1);
      drv(6'b100110);
      cyc(20);
      chk(16'({pin, ready}), 16'h0);
      cyc(40);
      chk(16'(pin), 16'h1);
      for (int i = 1; i < 4; i++) begin
         wr(10'h146, 8'(i << 4));
         drv(6'b110110);
         cyc(3);
         drv(6'b100110);
         cyc(w[i] - 10);
         chk(16'(pin), 16'h0);
         cyc(20);
         chk(16'(pin), 16'h1);
      end
      wr(10'h146, 8'h80);
      drv(6'b100010);
      cyc(3);
      drv(6'b100110);
      cyc(1000);
      chk(16'(pin), 16'h0);
      cyc(1100);
      chk(16'(pin), 16'h1);
   endtask
   task automatic t_release();
      wr(10'h143, 8'h01);
      wr(10'h146, 8'h00);
      drv(6'b100001);
      cyc(3);
      drv(6'b000001);
      for (n = 0; n < 40 && oe === 1'b1; n++) cyc(1);
      chk(16'(n >= 15 && n <= 20), 16'h1);
      chk(16'(clr_cnt), 16'h1);
      wr(10'h146, 8'h44);
      drv(6'b100001);
      cyc(3);
      drv(6'b000001);
      cyc(30);
      chk(16'({oe, 8'(clr_cnt)}), 16'h101);
      drv(6'b001001);
      cyc(3);
      chk(16'(oe), 16'h0);
   endtask
   task automatic t_stuck();
      @(posedge sys_clk);
      sclk <= 1'b0;
      cyc(40);
      chk(16'(twr_cnt), 16'h0);
      sclk <= 1'b1;
      wr(10'h143, 8'h10);
      sclk <= 1'b0;
      cyc(18);
      chk(16'(twr_cnt), 16'h0);
      cyc(22);
      chk(16'(twr_cnt), 16'h1);
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(5);
      t_regs();
      t_alarm();
      t_masks();
      t_release();
      t_stuck();
      results();
   end
   initial begin
      #(50 * 20000);
      err_total++;
      results();
   end
endmodule // buck_app_config_regs_test
